/* osssc_pkg.sv */
// Package with register map, field positions and timing constants for the sync control block.
package osssc_pkg;
  localparam logic [7:0] SYSCTL_ADDR = 8'h0d;
  localparam logic [7:0] SYNCCTL_ADDR = 8'h10;
  localparam logic [7:0] STATUS_ADDR = 8'h11;
  localparam logic [7:0] SYSCTL_RST = 8'h00;
  localparam logic [7:0] SYNCCTL_RST = 8'h00;
  localparam int SYS_SOFT_RESET_BIT = 0;
  localparam int SYS_POWER_SAVE_BIT = 1;
  localparam int SYS_DYN_PD_BIT = 2;
  localparam int SYS_ONE_CH_BIT = 3;
  localparam int SYNC_PIN_FN_LSB = 0;
  localparam int SYNC_RESYNC_BIT = 4;
  localparam int SYNC_TS_BIT = 7;
  localparam logic [3:0] PIN_FN_INTERNAL = 4'h0;
  localparam logic [3:0] PIN_FN_SLAVE_A = 4'h2;
  localparam logic [3:0] PIN_FN_SLAVE_B = 4'h3;
  localparam logic [3:0] PIN_FN_MASTER_A = 4'h4;
  localparam logic [3:0] PIN_FN_MASTER_B = 4'h5;
  localparam int CLK_HZ = 25000000;
  localparam int OSC_HZ = 32768;
  // Cycles of mclk per tick of the sampling oscillator, rounded down.
  localparam int OSC_DIV = CLK_HZ / OSC_HZ;
  localparam int DYN_PD_MAX_SPS = 256;
  localparam logic [2:0] TS_BLOCK_LAST = 3'h7;
  localparam logic [3:0] SOFT_RESET_CYCLES = 4'h8;
  localparam logic [7:0] CONV_TICKS = 8'h10;
  typedef enum logic [1:0] {OSSSC_IDLE, OSSSC_CONV, OSSSC_GAP} osssc_state_t;
endpackage

/* osssc_top.sv */
// Top module of the sync control block: two control registers and sample sequencing.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ns
module osssc_top #(
  parameter bit DUAL_CHANNEL = 1'b1
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic resetn,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Sample rate and raw conversion result from the analog front end.
  input wire logic [11:0] sample_rate_sps,
  input wire logic [7:0] conv_data,
  // Interrupt flags raised elsewhere in the part.
  input wire logic [3:0] irq_flags_in,
  output logic [3:0] irq_flags,
  // General purpose pins.
  input wire logic gp1_in,
  output logic gp1_out,
  output logic gp1_oe,
  output logic gp2_enable,
  // Operating state outputs.
  output logic first_channel_on,
  output logic second_channel_on,
  output logic osc_running,
  output logic analog_powered,
  output logic conv_active,
  output logic [7:0] conv_result,
  output logic timestamp_push,
  output logic soft_reset_pulse,
  output logic use_external_clock
);
  logic rst_meta_r;
  logic rst_sync_r;
  logic gp1_meta_r;
  logic gp1_sync_r;
  logic gp1_prev_r;
  logic [7:0] sysctl_r;
  logic [7:0] syncctl_r;
  logic [3:0] srst_cnt_r;
  logic [15:0] osc_cnt_r;
  logic [7:0] conv_cnt_r;
  logic [2:0] ts_cnt_r;
  logic [7:0] result_r;
  logic [7:0] rdata_r;
  logic ts_push_r;
  logic master_out_r;
  osssc_pkg::osssc_state_t state_r;
  osssc_pkg::osssc_state_t state_nxt;

  // Synchronised reset release.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // Decoded control fields.
  wire sys_wr = reg_wr && (reg_addr == osssc_pkg::SYSCTL_ADDR);
  wire sync_wr = reg_wr && (reg_addr == osssc_pkg::SYNCCTL_ADDR);
  wire power_save = sysctl_r[osssc_pkg::SYS_POWER_SAVE_BIT];
  wire soft_reset_busy = sysctl_r[osssc_pkg::SYS_SOFT_RESET_BIT];
  wire one_channel_select = sysctl_r[osssc_pkg::SYS_ONE_CH_BIT];
  wire dynamic_power_down = sysctl_r[osssc_pkg::SYS_DYN_PD_BIT];
  wire timestamp_push_enable = syncctl_r[osssc_pkg::SYNC_TS_BIT];
  wire software_resync = syncctl_r[osssc_pkg::SYNC_RESYNC_BIT];
  wire [3:0] pin_fn = syncctl_r[osssc_pkg::SYNC_PIN_FN_LSB +: 4];
  wire slave_mode = (pin_fn == osssc_pkg::PIN_FN_SLAVE_A) ||
                    (pin_fn == osssc_pkg::PIN_FN_SLAVE_B);
  wire master_mode = (pin_fn == osssc_pkg::PIN_FN_MASTER_A) ||
                     (pin_fn == osssc_pkg::PIN_FN_MASTER_B);
  wire low_rate = ({20'h00000, sample_rate_sps} <= osssc_pkg::DYN_PD_MAX_SPS);
  wire srst_done = soft_reset_busy && (srst_cnt_r == osssc_pkg::SOFT_RESET_CYCLES);
  wire srst_start = sys_wr && reg_wdata[osssc_pkg::SYS_SOFT_RESET_BIT] && !soft_reset_busy;
  wire run = !power_save && !soft_reset_busy;
  wire osc_tick = run && (osc_cnt_r == 16'(osssc_pkg::OSC_DIV - 1));
  wire trig_edge = gp1_sync_r && !gp1_prev_r;
  wire sample_start = slave_mode ? (run && trig_edge) : osc_tick;
  wire conv_done = (state_r == osssc_pkg::OSSSC_CONV) && osc_tick &&
                   (conv_cnt_r == osssc_pkg::CONV_TICKS - 8'h01);

  // Register bank with self-clearing bits; soft reset zeroes both registers.
  always_ff @(posedge mclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      sysctl_r <= osssc_pkg::SYSCTL_RST;
      syncctl_r <= osssc_pkg::SYNCCTL_RST;
      srst_cnt_r <= 4'h0;
    end else if (srst_done) begin
      sysctl_r <= osssc_pkg::SYSCTL_RST;
      syncctl_r <= osssc_pkg::SYNCCTL_RST;
      srst_cnt_r <= 4'h0;
    end else if (soft_reset_busy) begin
      srst_cnt_r <= srst_cnt_r + 4'h1;
    end else begin
      if (sys_wr) begin
        sysctl_r <= {4'h0, reg_wdata[3:0]};
      end
      if (sync_wr) begin
        syncctl_r <= {reg_wdata[7], 2'b00, reg_wdata[4:0]};
      end else if (software_resync) begin
        syncctl_r[osssc_pkg::SYNC_RESYNC_BIT] <= 1'b0;
      end
    end
  end

  // Pin synchroniser for the trigger input.
  always_ff @(posedge mclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      gp1_meta_r <= 1'b0;
      gp1_sync_r <= 1'b0;
      gp1_prev_r <= 1'b0;
    end else begin
      gp1_meta_r <= gp1_in;
      gp1_sync_r <= gp1_meta_r;
      gp1_prev_r <= gp1_sync_r;
    end
  end

  // Internal sampling oscillator divider, halted in power save.
  always_ff @(posedge mclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      osc_cnt_r <= 16'h0000;
    end else if (!run) begin
      osc_cnt_r <= 16'h0000;
    end else if (osc_tick) begin
      osc_cnt_r <= 16'h0000;
    end else begin
      osc_cnt_r <= osc_cnt_r + 16'h0001;
    end
  end

  // Sample sequencer.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      osssc_pkg::OSSSC_IDLE: begin
        if (sample_start) begin
          state_nxt = osssc_pkg::OSSSC_CONV;
        end
      end
      osssc_pkg::OSSSC_CONV: begin
        if (conv_done) begin
          state_nxt = osssc_pkg::OSSSC_GAP;
        end
      end
      osssc_pkg::OSSSC_GAP: begin
        if (sample_start) begin
          state_nxt = osssc_pkg::OSSSC_CONV;
        end
      end
      default: begin
        state_nxt = osssc_pkg::OSSSC_IDLE;
      end
    endcase
    if (!run) begin
      state_nxt = osssc_pkg::OSSSC_IDLE;
    end else if (software_resync) begin
      state_nxt = osssc_pkg::OSSSC_CONV;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      state_r <= osssc_pkg::OSSSC_IDLE;
      conv_cnt_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      if (state_nxt != osssc_pkg::OSSSC_CONV || state_r != osssc_pkg::OSSSC_CONV ||
          software_resync) begin
        conv_cnt_r <= 8'h00;
      end else if (osc_tick) begin
        conv_cnt_r <= conv_cnt_r + 8'h01;
      end
    end
  end

  // Result capture, timestamp block counter and master sample output.
  always_ff @(posedge mclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      result_r <= 8'h00;
      ts_cnt_r <= 3'h0;
      ts_push_r <= 1'b0;
      master_out_r <= 1'b0;
    end else if (soft_reset_busy) begin
      result_r <= 8'h00;
      ts_cnt_r <= 3'h0;
      ts_push_r <= 1'b0;
      master_out_r <= 1'b0;
    end else begin
      ts_push_r <= 1'b0;
      master_out_r <= master_mode && run && sample_start;
      if (conv_done && run) begin
        result_r <= conv_data;
        ts_cnt_r <= ts_cnt_r + 3'h1;
        ts_push_r <= timestamp_push_enable && (ts_cnt_r == osssc_pkg::TS_BLOCK_LAST);
      end
    end
  end

  // Read data, one cycle after the read strobe.
  wire [7:0] status_val = {5'h00, state_r == osssc_pkg::OSSSC_CONV, osc_running, analog_powered};
  wire [7:0] rd_mux = (reg_addr == osssc_pkg::SYSCTL_ADDR) ? sysctl_r :
                      (reg_addr == osssc_pkg::SYNCCTL_ADDR) ? syncctl_r :
                      (reg_addr == osssc_pkg::STATUS_ADDR) ? status_val : 8'h00;
  always_ff @(posedge mclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      rdata_r <= rd_mux;
    end
  end

  assign reg_rdata = rdata_r;
  assign irq_flags = power_save ? 4'h0 : irq_flags_in;
  assign first_channel_on = run;
  assign second_channel_on = run && (!DUAL_CHANNEL ? 1'b0 : !one_channel_select);
  assign osc_running = run;
  assign analog_powered = run && !(dynamic_power_down && low_rate &&
                                   state_r != osssc_pkg::OSSSC_CONV);
  assign conv_active = state_r == osssc_pkg::OSSSC_CONV;
  assign conv_result = result_r;
  assign timestamp_push = ts_push_r;
  assign soft_reset_pulse = srst_start;
  assign gp1_out = master_out_r;
  assign gp1_oe = master_mode;
  assign gp2_enable = pin_fn != osssc_pkg::PIN_FN_INTERNAL;
  assign use_external_clock = pin_fn == osssc_pkg::PIN_FN_SLAVE_B ||
                              pin_fn == osssc_pkg::PIN_FN_MASTER_B;
endmodule

/* osssc_props.sv */
// Checker with concurrent properties for the sync control block.
`timescale 1ns/1ns
module osssc_props #(
  parameter bit DUAL_CHANNEL = 1'b1
) (
  // Clock, reset and register port.
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  // Levels and flags.
  input wire logic [11:0] sample_rate_sps,
  input wire logic [3:0] irq_flags_in,
  input wire logic [3:0] irq_flags,
  input wire logic gp1_out,
  input wire logic gp1_oe,
  input wire logic first_channel_on,
  input wire logic second_channel_on,
  input wire logic osc_running,
  input wire logic analog_powered,
  input wire logic conv_active,
  input wire logic [7:0] conv_result,
  input wire logic soft_reset_pulse
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Oscillator held off for the reset sequence, then running again.
  sequence s_reset_busy;
    !osc_running [*6] ##[1:6] osc_running;
  endsequence
  AST_SRST: assert property (soft_reset_pulse |=> s_reset_busy)
    else $error("soft reset sequence length wrong");
  AST_IRQ: assert property (irq_flags == irq_flags_in || irq_flags == 4'h0)
    else $error("interrupt flags corrupted");
  AST_OSC: assert property (!osc_running |-> !analog_powered)
    else $error("analog powered with oscillator stopped");
  AST_STOP: assert property (!osc_running [*2] |-> !conv_active)
    else $error("conversion survives power save");
  AST_RESULT: assert property ($changed(conv_result) |-> $past(conv_active) || conv_result == 8'h00)
    else $error("result changed outside a conversion");
  AST_OE: assert property (gp1_out |-> gp1_oe ##1 !gp1_out)
    else $error("master pulse wrong");
  AST_CHAN: assert property (second_channel_on |-> first_channel_on && DUAL_CHANNEL)
    else $error("second channel wrongly on");
  AST_RATE: assert property ((osc_running && sample_rate_sps > 12'd256) [*3] |-> analog_powered)
    else $error("power down above rate limit");
  AST_RESYNC: assert property (reg_wr && reg_addr == 8'h10 && reg_wdata[4] && osc_running
    |-> ##[1:800] conv_active)
    else $error("resync did not start a sample");
endmodule
bind osssc_top osssc_props #(.DUAL_CHANNEL(DUAL_CHANNEL)) u_props (.mclk, .resetn, .reg_addr,
  .reg_wdata, .reg_wr, .sample_rate_sps, .irq_flags_in, .irq_flags, .gp1_out, .gp1_oe,
  .first_channel_on, .second_channel_on, .osc_running, .analog_powered, .conv_active,
  .conv_result, .soft_reset_pulse);

/* testbench.sv */
// Self-checking testbench for the sync control block.
`timescale 1ns/1ns
module testbench;
  localparam logic [7:0] SYS = osssc_pkg::SYSCTL_ADDR;
  localparam logic [7:0] SYN = osssc_pkg::SYNCCTL_ADDR;
  logic mclk, resetn, reg_wr, reg_rd, gp1_in, gp1_out, gp1_oe, gp2_enable;
  logic first_channel_on, second_channel_on, osc_running, analog_powered, conv_active;
  logic timestamp_push, soft_reset_pulse, use_external_clock;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, conv_data, conv_result, d;
  logic [11:0] sample_rate_sps;
  logic [3:0] irq_flags_in, irq_flags;
  logic gp1_man, gp1_lvl;
  integer seed, err_count, total_checks, i;
  osssc_top dut (.mclk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .sample_rate_sps, .conv_data, .irq_flags_in, .irq_flags, .gp1_in, .gp1_out, .gp1_oe,
    .gp2_enable, .first_channel_on, .second_channel_on, .osc_running, .analog_powered,
    .conv_active, .conv_result, .timestamp_push, .soft_reset_pulse, .use_external_clock);
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    conv_data <= 8'($random(seed));
    irq_flags_in <= 4'($random(seed));
    gp1_in <= gp1_man ? gp1_lvl : 1'($random(seed));
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk(reg_rdata, exp);
  endtask
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #(40 * 30000);
    err_count++;
    end_sim();
  end
  initial begin
    seed = 50;
    err_count = 0;
    total_checks = 0;
    {resetn, reg_wr, reg_rd, gp1_in, reg_addr, reg_wdata} = '0;
    {conv_data, irq_flags_in, gp1_man, gp1_lvl} = '0;
    sample_rate_sps = 12'd1000;
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    repeat (2) @(posedge mclk);
    rd(SYS, osssc_pkg::SYSCTL_RST);
    rd(SYN, osssc_pkg::SYNCCTL_RST);
    rd(8'h20, 8'h00);
    @(posedge mclk);
    sample_rate_sps <= 12'd200;
    wr(SYS, 8'h04);
    @(negedge mclk);
    chk({7'h0, analog_powered}, 8'h00);
    @(posedge mclk);
    sample_rate_sps <= 12'd1000;
    @(negedge mclk);
    chk({7'h0, analog_powered}, 8'h01);
    for (i = 0; i < 12; i++) begin
      d = 8'($random(seed)) & 8'hee;
      wr(SYS, d);
      rd(SYS, d & 8'h0e);
      if (!d[1]) chk({7'h0, second_channel_on}, {7'h0, !d[3]});
      if (d[1]) chk({4'h0, irq_flags}, 8'h00);
      d = 8'($random(seed)) & 8'hef;
      wr(SYN, d);
      rd(SYN, d & 8'h8f);
    end
    wr(SYS, 8'h00);
    for (i = 0; i < 6; i++) begin
      wr(SYN, 8'(i));
      @(negedge mclk);
      chk({7'h0, gp1_oe}, {7'h0, i == 4 || i == 5});
      chk({7'h0, gp2_enable}, {7'h0, i != 0});
      chk({7'h0, use_external_clock}, {7'h0, i == 3 || i == 5});
    end
    @(posedge mclk);
    gp1_man <= 1'b1;
    gp1_lvl <= 1'b0;
    wr(SYS, 8'h02);
    wr(SYN, 8'h02);
    wr(SYS, 8'h00);
    repeat (4) @(negedge mclk);
    chk({7'h0, conv_active}, 8'h00);
    @(posedge mclk);
    gp1_lvl <= 1'b1;
    repeat (6) @(negedge mclk);
    chk({7'h0, conv_active}, 8'h01);
    wr(SYS, 8'h04);
    wr(SYN, 8'h14);
    rd(SYN, 8'h04);
    repeat (800) @(negedge mclk);
    chk({7'h0, conv_active}, 8'h01);
    d = conv_result;
    wr(SYS, 8'h06);
    repeat (2) @(negedge mclk);
    chk({7'h0, conv_active}, 8'h00);
    repeat (50) @(posedge mclk);
    chk(conv_result, d);
    rd(osssc_pkg::STATUS_ADDR, 8'h00);
    wr(SYN, 8'h85);
    wr(SYS, 8'h0d);
    rd(SYS, 8'h0d);
    wr(SYN, 8'h8f);
    repeat (12) @(posedge mclk);
    rd(SYS, 8'h00);
    rd(SYN, 8'h00);
    end_sim();
  end
endmodule
